// *** pkg/pulse_gen_defs.vh ***
`ifndef PULSE_GEN_DEFS_VH
`define PULSE_GEN_DEFS_VH

// Register byte offsets
`define OFS_TIMER_CONTROL 4'h0
`define OFS_PERIOD_COMPARE 4'h4
`define OFS_TOGGLE_COMPARE 4'h8
`define OFS_COUNT 4'hc
`define OFS_STATUS 5'h10
`define OFS_MASK 5'h14

// timer_control fields
`define START_SELECT_LSB 0
`define START_SELECT_MSB 1
`define REPEAT_SELECT_BIT 2
`define OUTPUT_FLOP_BIT 3
`define MODE_SELECT_BIT 4
`define CLK_DIV_LSB 8
`define CLK_DIV_MSB 15

// start_select codes
`define START_STOP 2'h0
`define START_COMMAND 2'h1
`define START_RISING 2'h2
`define START_FALLING 2'h3

// mode_select codes
`define MODE_TIMER 1'h0
`define MODE_PULSE 1'h1

// status / mask bits
`define STATUS_MATCH_BIT 0
`define STATUS_PIN_BIT 1
`define STATUS_RUN_BIT 2

// Reset values
`define TIMER_CONTROL_RESET 32'h0000_0000
`define COMPARE_RESET 16'hffff
`define MASK_RESET 1'h0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** rtl/timer_pulse_generator_output.v ***
`include "pulse_gen_defs.vh"

// Function
// - The counter starts on the chosen edge of the timer input pin or on a command start.
// - A repeat select of 0 gives continuous pulses and 1 gives a single shot.
// - On a toggle compare match the output inverts and an interrupt is raised, counting on.
// - On a period match in continuous use the output inverts, interrupt rises, counter clears.
// - Writing stop to the start select halts the counter and the pin keeps its level.
// - In one shot a period match inverts the output, interrupts, clears start select, stops.
// - The pin is the inverse of the output flip flop, so control bit 0 gives high, 1 low.
// - Reset clears the output flip flop so the pin starts high.
// - Going from timer mode to pulse mode with the flop bit reloads the flip flop.
// - Once stopped inverted from its start level, a flop bit write loads its inverse.
module timer_pulse_generator_output (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [4:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [4:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Timer pins
  input wire timer_input_pin,
  output reg pulse_output_pin,
  // Events
  output reg match_interrupt,
  output reg irq
);

  // Write channel holding
  reg aw_held_reg;
  reg w_held_reg;
  reg [4:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  // Programmable state
  reg [1:0] start_select_reg;
  reg pulse_repeat_select_reg;
  reg output_flop_control_reg;
  reg mode_select_reg;
  reg [7:0] clk_div_reg;
  reg [15:0] period_compare_reg;
  reg [15:0] toggle_compare_reg;
  reg mask_reg;
  reg status_match_reg;

  // Timer state
  reg output_flip_flop_reg;
  reg start_flop_reg;
  reg running_reg;
  reg [15:0] count_reg;
  reg [7:0] prescale_reg;
  reg tin_prev_reg;

  // Next values
  reg [1:0] start_select_next;
  reg pulse_repeat_select_next;
  reg output_flop_control_next;
  reg mode_select_next;
  reg [7:0] clk_div_next;
  reg output_flip_flop_next;
  reg start_flop_next;
  reg running_next;
  reg [15:0] count_next;
  reg match_next;
  reg status_match_next;

  wire do_write;
  wire [31:0] byte_mask;
  wire [31:0] ctrl_cur;
  wire [31:0] ctrl_wr;
  wire [31:0] period_wr;
  wire [31:0] toggle_wr;
  wire ctrl_we;
  wire period_we;
  wire toggle_we;
  wire status_we;
  wire mask_we;
  wire wr_mapped;
  wire rd_mapped;
  wire src_tick;
  wire tin_rise;
  wire tin_fall;
  reg [31:0] rd_value;

  // Write happens once address and data are both held
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign byte_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                      {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign ctrl_cur = {16'h0000, clk_div_reg, 3'h0, mode_select_reg,
                     output_flop_control_reg, pulse_repeat_select_reg, start_select_reg};
  assign ctrl_wr = (wdata_reg & byte_mask) | (ctrl_cur & ~byte_mask);
  assign period_wr = (wdata_reg & byte_mask) | ({16'h0000, period_compare_reg} & ~byte_mask);
  assign toggle_wr = (wdata_reg & byte_mask) | ({16'h0000, toggle_compare_reg} & ~byte_mask);
  assign ctrl_we = do_write && (waddr_reg == {1'b0, `OFS_TIMER_CONTROL});
  assign period_we = do_write && (waddr_reg == {1'b0, `OFS_PERIOD_COMPARE});
  // Toggle compare only writable in pulse mode
  assign toggle_we = do_write && (waddr_reg == {1'b0, `OFS_TOGGLE_COMPARE}) &&
                     (mode_select_reg == `MODE_PULSE);
  assign status_we = do_write && (waddr_reg == `OFS_STATUS) && wstrb_reg[0];
  assign mask_we = do_write && (waddr_reg == `OFS_MASK) && wstrb_reg[0];
  assign wr_mapped = (waddr_reg[1:0] == 2'h0) && (waddr_reg <= `OFS_MASK) &&
                     (waddr_reg != {1'b0, `OFS_COUNT});
  assign rd_mapped = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `OFS_MASK);

  // Source clock tick from the divider, only while running
  assign src_tick = running_reg && (prescale_reg == clk_div_reg);
  // Start edges on the timer input pin
  assign tin_rise = timer_input_pin && !tin_prev_reg;
  assign tin_fall = !timer_input_pin && tin_prev_reg;

  // Timer next-state logic
  always @* begin
    start_select_next = start_select_reg;
    pulse_repeat_select_next = pulse_repeat_select_reg;
    output_flop_control_next = output_flop_control_reg;
    mode_select_next = mode_select_reg;
    clk_div_next = clk_div_reg;
    output_flip_flop_next = output_flip_flop_reg;
    start_flop_next = start_flop_reg;
    running_next = running_reg;
    count_next = count_reg;
    match_next = 1'b0;
    if (running_reg) begin
      if (src_tick) begin
        if (count_reg == period_compare_reg) begin
          output_flip_flop_next = ~output_flip_flop_reg;
          match_next = 1'b1;
          count_next = 16'h0000;
          if (pulse_repeat_select_reg) begin
            start_select_next = `START_STOP;
            running_next = 1'b0;
          end
        end else begin
          if (count_reg == toggle_compare_reg) begin
            output_flip_flop_next = ~output_flip_flop_reg;
            match_next = 1'b1;
          end
          count_next = count_reg + 16'h0001;
        end
      end
    end else if (mode_select_reg == `MODE_PULSE) begin
      // Start by command or by the chosen pin edge
      if ((start_select_reg == `START_COMMAND) ||
          ((start_select_reg == `START_RISING) && tin_rise) ||
          ((start_select_reg == `START_FALLING) && tin_fall)) begin
        running_next = 1'b1;
        count_next = 16'h0000;
        start_flop_next = output_flip_flop_reg;
      end
    end
    // Software write of the control register wins over the auto stop
    if (ctrl_we) begin
      start_select_next = ctrl_wr[`START_SELECT_MSB:`START_SELECT_LSB];
      pulse_repeat_select_next = ctrl_wr[`REPEAT_SELECT_BIT];
      output_flop_control_next = ctrl_wr[`OUTPUT_FLOP_BIT];
      mode_select_next = ctrl_wr[`MODE_SELECT_BIT];
      clk_div_next = ctrl_wr[`CLK_DIV_MSB:`CLK_DIV_LSB];
      if ((ctrl_wr[`START_SELECT_MSB:`START_SELECT_LSB] == `START_STOP) ||
          (ctrl_wr[`MODE_SELECT_BIT] != `MODE_PULSE)) begin
        running_next = 1'b0;
        count_next = 16'h0000;
      end
      // Flop reload only while stopped
      if (!running_reg && (ctrl_wr[`MODE_SELECT_BIT] == `MODE_PULSE)) begin
        if (mode_select_reg != `MODE_PULSE) begin
          output_flip_flop_next = ctrl_wr[`OUTPUT_FLOP_BIT];
          start_flop_next = ctrl_wr[`OUTPUT_FLOP_BIT];
        end else if (output_flip_flop_reg != start_flop_reg) begin
          output_flip_flop_next = ~ctrl_wr[`OUTPUT_FLOP_BIT];
        end else begin
          output_flip_flop_next = ctrl_wr[`OUTPUT_FLOP_BIT];
        end
      end
    end
  end

  // Sticky match flag, set wins over clear
  always @* begin
    status_match_next = status_match_reg;
    if (status_we && s_axi_wdata[`STATUS_MATCH_BIT] == 1'b0) begin
      status_match_next = status_match_reg;
    end
    if (status_we && wdata_reg[`STATUS_MATCH_BIT]) begin
      status_match_next = 1'b0;
    end
    if (match_next) begin
      status_match_next = 1'b1;
    end
  end

  // Timer and register state
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_select_reg <= `START_STOP;
      pulse_repeat_select_reg <= 1'b0;
      output_flop_control_reg <= 1'b0;
      mode_select_reg <= `MODE_TIMER;
      clk_div_reg <= 8'h00;
      period_compare_reg <= `COMPARE_RESET;
      toggle_compare_reg <= `COMPARE_RESET;
      mask_reg <= `MASK_RESET;
      status_match_reg <= 1'b0;
      output_flip_flop_reg <= 1'b0;
      start_flop_reg <= 1'b0;
      running_reg <= 1'b0;
      count_reg <= 16'h0000;
      prescale_reg <= 8'h00;
      tin_prev_reg <= 1'b0;
      pulse_output_pin <= 1'b1;
      match_interrupt <= 1'b0;
      irq <= 1'b0;
    end else begin
      start_select_reg <= start_select_next;
      pulse_repeat_select_reg <= pulse_repeat_select_next;
      output_flop_control_reg <= output_flop_control_next;
      mode_select_reg <= mode_select_next;
      clk_div_reg <= clk_div_next;
      if (period_we) begin
        period_compare_reg <= period_wr[15:0];
      end
      if (toggle_we) begin
        toggle_compare_reg <= toggle_wr[15:0];
      end
      if (mask_we) begin
        mask_reg <= wdata_reg[`STATUS_MATCH_BIT];
      end
      status_match_reg <= status_match_next;
      output_flip_flop_reg <= output_flip_flop_next;
      start_flop_reg <= start_flop_next;
      running_reg <= running_next;
      count_reg <= count_next;
      // Prescaler restarts with each tick or while idle
      if (!running_reg || src_tick) begin
        prescale_reg <= 8'h00;
      end else begin
        prescale_reg <= prescale_reg + 8'h01;
      end
      tin_prev_reg <= timer_input_pin;
      pulse_output_pin <= ~output_flip_flop_next;
      match_interrupt <= match_next;
      irq <= status_match_next && (mask_we ? wdata_reg[`STATUS_MATCH_BIT] : mask_reg);
    end
  end

  // Write address and data capture, then response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data selection
  always @* begin
    rd_value = 32'h0000_0000;
    case (s_axi_araddr)
      {1'b0, `OFS_TIMER_CONTROL}: rd_value = ctrl_cur;
      {1'b0, `OFS_PERIOD_COMPARE}: rd_value = {16'h0000, period_compare_reg};
      {1'b0, `OFS_TOGGLE_COMPARE}: rd_value = {16'h0000, toggle_compare_reg};
      {1'b0, `OFS_COUNT}: rd_value = {16'h0000, count_reg};
      `OFS_STATUS: rd_value = {29'h0000_0000, running_reg, pulse_output_pin, status_match_reg};
      `OFS_MASK: rd_value = {31'h0000_0000, mask_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Read channel, one answer at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** sim/pulse_gen_sva.sv ***
module pulse_gen_sva (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Pin and events
  input wire pulse_output_pin,
  input wire match_interrupt,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin moves only on a match or a control write
  a_pin_needs_cause: assert property ($changed(pulse_output_pin) |->
    match_interrupt || s_axi_bvalid) else $error("pin moved without cause");
  a_irq_with_toggle: assert property (match_interrupt |->
    $changed(pulse_output_pin)) else $error("match pulse without toggle");
  a_reset_levels: assert property ($rose(aresetn) |-> pulse_output_pin && !irq &&
    !match_interrupt && !s_axi_bvalid && !s_axi_rvalid) else $error("bad reset levels");
  a_irq_rise_cause: assert property ($rose(irq) |-> match_interrupt || s_axi_bvalid)
    else $error("irq rose without cause");
  // Bus answer timing
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  // Main scenarios
  cover property (match_interrupt);
  cover property ($fell(pulse_output_pin));
  cover property ($rose(irq));
endmodule

bind timer_pulse_generator_output pulse_gen_sva pulse_gen_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .pulse_output_pin(pulse_output_pin), .match_interrupt(match_interrupt), .irq(irq));

// *** sim/pulse_load_model.sv ***
module pulse_load_model (
  // Clock
  input wire aclk,
  // Driven pin
  input wire pulse_output_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int stamps[$];
  logic last = 1'h1;
  // Logs the cycle of every level change
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pulse_output_pin !== last) stamps.push_back(cyc);
    last <= pulse_output_pin;
  end
endmodule

// *** sim/timer_pulse_generator_output_tb.sv ***
module timer_pulse_generator_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0;
  logic arv = 1'h0, rre = 1'h0, tin = 1'h0;
  logic [4:0] awa = 5'h0, ara = 5'h0;
  logic [31:0] wd = 32'h0, rd, got;
  logic [1:0] br, rr;
  logic awr, wrd, bv, arr, rv, pin, mi, irq;
  logic [15:0] seed = 16'hc852;
  int err_count = 0, compares = 0;
  int t, p, d, n0, c, m0, mi_count;
  int s[$];
  // Clock
  always #12.5 aclk = ~aclk;
  timer_pulse_generator_output timer_pulse_generator_output_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .timer_input_pin(tin), .pulse_output_pin(pin),
    .match_interrupt(mi), .irq(irq));
  pulse_load_model pulse_load_model_inst (.aclk(aclk), .pulse_output_pin(pin));
  // Counts match pulses
  always @(posedge aclk) begin
    if (mi === 1'h1) mi_count <= mi_count + 1;
  end
  function logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function int ne();
    return pulse_load_model_inst.stamps.size();
  endfunction
  task final_report;
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task hang;
    chk("timeout", 32'h0, 32'h1);
    final_report;
  endtask
  // Bus write with bounded wait for the response
  task wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] e);
    int n;
    logic dn;
    @(posedge aclk);
    dn = 1'h0;
    awa <= a;
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    for (n = 0; n < 99 && !dn; n++) begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
      if (bv) begin
        bre <= 1'h0;
        dn = 1'h1;
        chk("bresp", e, br);
      end
    end
    if (!dn) hang;
  endtask
  // Bus read, data left in got
  task rdr(input logic [4:0] a, input logic [1:0] e);
    int n;
    logic dn;
    @(posedge aclk);
    dn = 1'h0;
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    for (n = 0; n < 99 && !dn; n++) begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
      if (rv) begin
        rre <= 1'h0;
        dn = 1'h1;
        got = rd;
        chk("rresp", e, rr);
      end
    end
    if (!dn) hang;
  endtask
  task wait_edges(input int k);
    int n;
    for (n = 0; n < 5000 && ne() < k; n++) @(posedge aclk);
    if (n == 5000) hang;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("pin", 32'h1, pin);
    pulse_load_model_inst.stamps.delete();
    rdr(5'h04, 2'h0);
    chk("period", 32'hffff, got);
    rdr(5'h18, 2'h2);
    wr(5'h0c, 32'h0, 2'h2);
    // Continuous run with random compares and divider
    seed = lfsr(seed);
    t = 1 + seed[2:0];
    p = t + 8 + seed[5:3];
    d = seed[7:6];
    wr(5'h00, 32'h10 | d << 8, 2'h0);
    wr(5'h04, p, 2'h0);
    wr(5'h08, t, 2'h0);
    wr(5'h00, 32'h11 | d << 8, 2'h0);
    wait_edges(5);
    s = pulse_load_model_inst.stamps;
    for (n0 = 1; n0 < 4; n0++)
      chk("gap", ((n0 % 2) ? p - t : t + 1) * (d + 1), s[n0] - s[n0 - 1]);
    chk("pin", 32'h0, pin);
    // Stop holds the level
    wr(5'h00, 32'h10, 2'h0);
    n0 = ne();
    repeat (99) @(posedge aclk);
    chk("edges", n0, ne());
    chk("pin", 32'h0, pin);
    wr(5'h00, 32'h18, 2'h0);
    chk("pin", 32'h1, pin);
    wr(5'h00, 32'h08, 2'h0);
    wr(5'h00, 32'h18, 2'h0);
    chk("pin", 32'h0, pin);
    wr(5'h00, 32'h00, 2'h0);
    wr(5'h00, 32'h10, 2'h0);
    chk("pin", 32'h1, pin);
    wr(5'h08, 32'h2, 2'h0);
    wr(5'h04, 32'h5, 2'h0);
    // One shot under each start code
    for (c = 1; c < 4; c++) begin
      tin <= (c == 3);
      n0 = ne();
      m0 = mi_count;
      wr(5'h00, 32'h14 | c, 2'h0);
      repeat (9) @(posedge aclk);
      if (c > 1) chk("idle", n0, ne());
      tin <= (c == 2);
      wait_edges(n0 + 2);
      repeat (20) @(posedge aclk);
      chk("shot", n0 + 2, ne());
      chk("match", m0 + 2, mi_count);
      chk("pin", 32'h1, pin);
      rdr(5'h00, 2'h0);
      chk("ctrl", 32'h14, got);
    end
    // Sticky status, mask and clear
    chk("irq", 32'h0, irq);
    wr(5'h14, 32'h1, 2'h0);
    chk("irq", 32'h1, irq);
    wr(5'h10, 32'h1, 2'h0);
    chk("irq", 32'h0, irq);
    rdr(5'h10, 2'h0);
    chk("status", 32'h2, got);
    final_report;
  end
endmodule
